// File: include/crfdm_pkg.sv
// Package for the CPU register file and data-space decode block.
// Assumes a single 100 MHz system clock shared with decoder and ALU.
package crfdm_pkg;

    // Register file geometry
    localparam int REG_COUNT  = 32;             // Working registers
    localparam int REG_AW     = 5;              // Register number width
    localparam int DATA_W     = 8;              // Byte width
    localparam int PTR_W      = 16;             // Pointer width
    localparam int DISP_W     = 6;              // Displacement field width
    localparam int IO_AW      = 6;              // I/O field width
    localparam int SRAM_AW    = 7;              // SRAM address width
    localparam int SRAM_DEPTH = 128;            // SRAM bytes
    localparam int PC_W       = 10;             // Program counter width
    localparam int NVM_AW     = 7;              // Nonvolatile byte address

    // Upper half used by immediate forms
    localparam logic [REG_AW-1:0] IMM_BASE = 5'h10;

    // Pointer pair low-byte registers
    localparam logic [REG_AW-1:0] PTR_X_LO = 5'h1a;
    localparam logic [REG_AW-1:0] PTR_Y_LO = 5'h1c;
    localparam logic [REG_AW-1:0] PTR_Z_LO = 5'h1e;

    // Data space map
    localparam logic [PTR_W-1:0] IO_BASE   = 16'h0020;
    localparam logic [PTR_W-1:0] SRAM_BASE = 16'h0060;
    localparam logic [PTR_W-1:0] SPACE_END = 16'h00e0;
    localparam logic [PTR_W-1:0] PTR_STEP  = 16'h0001;

    // Reset values
    localparam logic [DATA_W-1:0] REG_RST  = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST   = 10'h000;
    localparam logic [DATA_W-1:0] UNDEF_RD = 8'h00;

    // Operand selection for the register port
    typedef enum logic [1:0] {
        CRFDM_SEL_ANY,   // Any register
        CRFDM_SEL_IMM,   // Upper sixteen only
        CRFDM_SEL_NONE
    } crfdm_sel_e;

    // ALU operation categories
    typedef enum logic [3:0] {
        CRFDM_ALU_ADD, CRFDM_ALU_ADC, CRFDM_ALU_SUB, CRFDM_ALU_SBC,
        CRFDM_ALU_AND, CRFDM_ALU_OR,  CRFDM_ALU_EOR, CRFDM_ALU_MOV,
        CRFDM_ALU_INC, CRFDM_ALU_DEC, CRFDM_ALU_COM, CRFDM_ALU_BSET,
        CRFDM_ALU_BCLR, CRFDM_ALU_CMP
    } crfdm_alu_e;

    // Data addressing modes
    typedef enum logic [2:0] {
        CRFDM_AM_NONE, CRFDM_AM_DIRECT, CRFDM_AM_IO, CRFDM_AM_IND,
        CRFDM_AM_DISP, CRFDM_AM_PREDEC, CRFDM_AM_POSTINC
    } crfdm_am_e;

    // Pointer selection
    typedef enum logic [1:0] {
        CRFDM_PTR_X, CRFDM_PTR_Y, CRFDM_PTR_Z
    } crfdm_ptr_e;

    // Region of a decoded data address
    typedef enum logic [1:0] {
        CRFDM_RGN_REG, CRFDM_RGN_IO, CRFDM_RGN_SRAM, CRFDM_RGN_NONE
    } crfdm_rgn_e;

    // ALU request from the decoder
    typedef struct packed {
        logic              valid;   // Execute this cycle
        crfdm_alu_e        op;      // Operation
        crfdm_sel_e        sel;     // Destination class
        logic [REG_AW-1:0] dst;     // Destination register
        logic [REG_AW-1:0] src;     // Source register
        logic              use_imm; // Immediate replaces source
        logic [DATA_W-1:0] imm;     // Immediate or bit number
        logic              carry;   // Carry in
    } crfdm_alu_req_s;

    // Data memory request from the decoder
    typedef struct packed {
        logic              valid;   // Access this cycle
        logic              write;   // Store when set
        crfdm_am_e         mode;    // Addressing mode
        crfdm_ptr_e        ptr;     // Pointer pair
        logic [PTR_W-1:0]  addr;    // Direct address word
        logic [IO_AW-1:0]  io_loc;  // I/O location field
        logic [DISP_W-1:0] disp;    // Displacement field
        logic [REG_AW-1:0] reg_num; // Source or destination register
    } crfdm_mem_req_s;

endpackage : crfdm_pkg

// File: src/crfdm_sram.sv
// Internal data SRAM, 128 bytes, registered read data.
// Assumes single clock; read and write addresses shared.
`timescale 1ns/10ps
module crfdm_sram
    import crfdm_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    // Access port
    input  wire logic               wr_en,
    input  wire logic [SRAM_AW-1:0] addr,
    input  wire logic [DATA_W-1:0]  wr_data,
    output logic      [DATA_W-1:0]  rd_data
);

    logic [DATA_W-1:0] mem [SRAM_DEPTH];   // Storage, no reset
    logic [DATA_W-1:0] next_rd_data;       // Read value

    // Read path
    always_comb begin
        next_rd_data = mem[addr];
    end

    // Storage is not reset so it maps onto RAM
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    // Read data register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= REG_RST;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule : crfdm_sram

// File: src/crfdm_regfile.sv
// Register file, pointers, data-space decode and single-cycle ALU.
// Assumes decoder holds requests stable; I/O peripherals sit outside
// and answer in the same cycle; the nonvolatile store is held inside.
`timescale 1ns/10ps
module crfdm_regfile
    import crfdm_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    // ALU request and result
    input  wire crfdm_alu_req_s     alu_req,
    output logic      [DATA_W-1:0]  alu_result,
    output logic                    alu_zero,
    output logic                    alu_carry,
    // Data memory request
    input  wire crfdm_mem_req_s     mem_req,
    output logic      [DATA_W-1:0]  mem_rd_data,
    output logic                    mem_rd_valid,
    // I/O window
    output logic                    io_wr,
    output logic                    io_rd,
    output logic      [IO_AW-1:0]   io_addr,
    output logic      [DATA_W-1:0]  io_wr_data,
    input  wire logic [DATA_W-1:0]  io_rd_data,
    // Program counter
    input  wire logic               pc_load,
    input  wire logic [PC_W-1:0]    pc_target,
    output logic      [PC_W-1:0]    program_counter,
    // Separate nonvolatile byte space
    input  wire logic               nvm_rd,
    input  wire logic               nvm_wr,
    input  wire logic [NVM_AW-1:0]  nvm_addr,
    input  wire logic [DATA_W-1:0]  nvm_wr_data,
    output logic      [DATA_W-1:0]  nvm_rd_data
);

    logic [DATA_W-1:0] regs [REG_COUNT];       // Working registers
    logic [DATA_W-1:0] next_regs [REG_COUNT];  // Next working registers
    logic [PC_W-1:0]   next_program_counter;   // Next PC
    logic [DATA_W-1:0] next_mem_rd_data;       // Next load data
    logic              next_mem_rd_valid;      // Next load strobe
    logic [DATA_W-1:0] next_alu_result;        // Next ALU result
    logic              next_alu_zero;          // Next zero flag
    logic              next_alu_carry;         // Next carry flag
    logic [PTR_W-1:0]  ptr_val;                // Selected pointer
    logic [PTR_W-1:0]  eff_addr;               // Effective address
    logic [PTR_W-1:0]  ptr_new;                // Updated pointer
    logic              ptr_upd;                // Pointer write-back
    logic [REG_AW-1:0] ptr_lo;                 // Pointer low register
    crfdm_rgn_e        rgn;                    // Decoded region
    logic              sram_wr;                // SRAM write strobe
    logic [DATA_W-1:0] sram_q;                 // SRAM read data
    logic              sram_pend;              // SRAM load in flight
    logic              next_sram_pend;         // Next pending flag
    logic [REG_AW-1:0] ld_reg;                 // Load target register
    logic [REG_AW-1:0] next_ld_reg;            // Next load target
    logic [DATA_W-1:0] nvm [SRAM_DEPTH];       // Nonvolatile bytes
    logic [DATA_W-1:0] next_nvm_rd_data;       // Next nvm read data
    logic [DATA_W-1:0] op_a;                   // First operand
    logic [DATA_W-1:0] op_b;                   // Second operand
    logic [REG_AW-1:0] alu_dst;                // Effective destination
    logic [DATA_W:0]   sum;                    // Extended sum

    // Data space region decode, shared by every mode
    function automatic crfdm_rgn_e decode_rgn(input logic [PTR_W-1:0] a);
        if (a < IO_BASE) begin
            decode_rgn = CRFDM_RGN_REG;
        end else if (a < SRAM_BASE) begin
            decode_rgn = CRFDM_RGN_IO;
        end else if (a < SPACE_END) begin
            decode_rgn = CRFDM_RGN_SRAM;
        end else begin
            decode_rgn = CRFDM_RGN_NONE;
        end
    endfunction : decode_rgn

    // Low register of a pointer pair
    function automatic logic [REG_AW-1:0] ptr_base(input crfdm_ptr_e p);
        case (p)
            CRFDM_PTR_X: ptr_base = PTR_X_LO;
            CRFDM_PTR_Y: ptr_base = PTR_Y_LO;
            default:     ptr_base = PTR_Z_LO;
        endcase
    endfunction : ptr_base

    // Register number forced into upper half for immediate forms
    function automatic logic [REG_AW-1:0] dst_fix(input logic [REG_AW-1:0] r,
                                                  input crfdm_sel_e s);
        dst_fix = (s == CRFDM_SEL_IMM) ? (r | IMM_BASE) : r;
    endfunction : dst_fix

    // Pointer, effective address and region
    always_comb begin
        ptr_lo  = ptr_base(mem_req.ptr);
        ptr_val = {regs[ptr_lo + 5'h01], regs[ptr_lo]};
        ptr_new = ptr_val;
        ptr_upd = 1'b0;
        case (mem_req.mode)
            CRFDM_AM_DIRECT: eff_addr = mem_req.addr;
            CRFDM_AM_IO:     eff_addr = IO_BASE
                                        + PTR_W'(mem_req.io_loc);
            CRFDM_AM_IND:    eff_addr = ptr_val;
            CRFDM_AM_DISP: begin
                // Only Y or Z carry a displacement; X falls back to Y
                eff_addr = {regs[(mem_req.ptr == CRFDM_PTR_Z ? PTR_Z_LO
                                  : PTR_Y_LO) + 5'h01],
                            regs[mem_req.ptr == CRFDM_PTR_Z ? PTR_Z_LO
                                 : PTR_Y_LO]}
                           + PTR_W'(mem_req.disp);
            end
            CRFDM_AM_PREDEC: begin
                ptr_new  = ptr_val - PTR_STEP;
                eff_addr = ptr_new;
                ptr_upd  = mem_req.valid;
            end
            CRFDM_AM_POSTINC: begin
                eff_addr = ptr_val;
                ptr_new  = ptr_val + PTR_STEP;
                ptr_upd  = mem_req.valid;
            end
            default:         eff_addr = mem_req.addr;
        endcase
        rgn = decode_rgn(eff_addr);
    end

    // I/O window strobes, answered combinationally by peripherals
    always_comb begin
        io_rd      = mem_req.valid && !mem_req.write
                     && rgn == CRFDM_RGN_IO;
        io_wr      = mem_req.valid && mem_req.write
                     && rgn == CRFDM_RGN_IO;
        io_addr    = IO_AW'(eff_addr - IO_BASE);
        io_wr_data = regs[mem_req.reg_num];
        sram_wr    = mem_req.valid && mem_req.write
                     && rgn == CRFDM_RGN_SRAM;
    end

    // Internal SRAM; loads take a second cycle
    crfdm_sram u_sram (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr_en   (sram_wr),
        .addr    (SRAM_AW'(eff_addr - SRAM_BASE)),
        .wr_data (regs[mem_req.reg_num]),
        .rd_data (sram_q)
    );

    // ALU: operands and result in one cycle
    always_comb begin
        alu_dst = dst_fix(alu_req.dst, alu_req.sel);
        op_a    = regs[alu_dst];
        op_b    = alu_req.use_imm ? alu_req.imm
                                  : regs[alu_req.src];
        sum     = {1'b0, op_a};
        next_alu_carry = 1'b0;
        case (alu_req.op)
            // Arithmetic
            CRFDM_ALU_ADD: sum = {1'b0, op_a} + {1'b0, op_b};
            CRFDM_ALU_ADC: sum = {1'b0, op_a} + {1'b0, op_b}
                                 + {8'h00, alu_req.carry};
            CRFDM_ALU_SUB,
            CRFDM_ALU_CMP: sum = {1'b0, op_a} - {1'b0, op_b};
            CRFDM_ALU_SBC: sum = {1'b0, op_a} - {1'b0, op_b}
                                 - {8'h00, alu_req.carry};
            CRFDM_ALU_INC: sum = {1'b0, op_a} + 9'h001;
            CRFDM_ALU_DEC: sum = {1'b0, op_a} - 9'h001;
            // Logical
            CRFDM_ALU_AND: sum = {1'b0, op_a & op_b};
            CRFDM_ALU_OR:  sum = {1'b0, op_a | op_b};
            CRFDM_ALU_EOR: sum = {1'b0, op_a ^ op_b};
            CRFDM_ALU_COM: sum = {1'b0, ~op_a};
            CRFDM_ALU_MOV: sum = {1'b0, op_b};
            // Bit functions, bit number in imm
            CRFDM_ALU_BSET: sum = {1'b0, op_a | (8'h01 << alu_req.imm[2:0])};
            CRFDM_ALU_BCLR: sum = {1'b0, op_a & ~(8'h01 << alu_req.imm[2:0])};
            default:        sum = {1'b0, op_a};
        endcase
        next_alu_result = sum[DATA_W-1:0];
        next_alu_carry  = sum[DATA_W];
        next_alu_zero   = (sum[DATA_W-1:0] == REG_RST);
    end

    // Working register next state: ALU, loads and pointer updates
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            next_regs[i] = regs[i];
        end
        // ALU write-back, same cycle as read
        if (alu_req.valid && alu_req.sel != CRFDM_SEL_NONE
            && alu_req.op != CRFDM_ALU_CMP) begin
            next_regs[alu_dst] = next_alu_result;
        end
        // Store into a working register through the data space
        if (mem_req.valid && mem_req.write && rgn == CRFDM_RGN_REG) begin
            next_regs[eff_addr[REG_AW-1:0]] =
                regs[mem_req.reg_num];
        end
        // Loads from register file or I/O complete at once
        if (mem_req.valid && !mem_req.write) begin
            if (rgn == CRFDM_RGN_REG) begin
                next_regs[mem_req.reg_num] =
                    regs[eff_addr[REG_AW-1:0]];
            end else if (rgn == CRFDM_RGN_IO) begin
                next_regs[mem_req.reg_num] = io_rd_data;
            end
        end
        // SRAM load lands one cycle later
        if (sram_pend) begin
            next_regs[ld_reg] = sram_q;
        end
        // Pointer write-back last so the step is kept
        if (ptr_upd) begin
            next_regs[ptr_lo]         = ptr_new[DATA_W-1:0];
            next_regs[ptr_lo + 5'h01] = ptr_new[PTR_W-1:DATA_W];
        end
    end

    // Load data and pending SRAM tracking
    always_comb begin
        next_sram_pend = mem_req.valid && !mem_req.write
                         && rgn == CRFDM_RGN_SRAM;
        next_ld_reg    = mem_req.reg_num;
        next_mem_rd_valid = mem_req.valid && !mem_req.write
                            && rgn != CRFDM_RGN_SRAM;
        case (rgn)
            CRFDM_RGN_REG: next_mem_rd_data = regs[eff_addr[REG_AW-1:0]];
            CRFDM_RGN_IO:  next_mem_rd_data = io_rd_data;
            default:       next_mem_rd_data = UNDEF_RD;
        endcase
        if (sram_pend) begin
            next_mem_rd_valid = 1'b1;
            next_mem_rd_data  = sram_q;
        end
    end

    // Program counter, wraps at 1K words
    always_comb begin
        next_program_counter = pc_load ? pc_target
                                       : program_counter + 10'h001;
    end

    // Separate nonvolatile space read
    always_comb begin
        next_nvm_rd_data = nvm_rd ? nvm[nvm_addr] : nvm_rd_data;
    end

    // Nonvolatile storage, no reset
    always_ff @(posedge clk_sys) begin
        if (nvm_wr) begin
            nvm[nvm_addr] <= nvm_wr_data;
        end
    end

    // Registered state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= REG_RST;
            end
            program_counter <= PC_RST;
            mem_rd_data     <= REG_RST;
            mem_rd_valid    <= 1'b0;
            sram_pend       <= 1'b0;
            ld_reg          <= 5'h00;
            alu_result      <= REG_RST;
            alu_zero        <= 1'b0;
            alu_carry       <= 1'b0;
            nvm_rd_data     <= REG_RST;
        end else begin
            regs            <= next_regs;
            program_counter <= next_program_counter;
            mem_rd_data     <= next_mem_rd_data;
            mem_rd_valid    <= next_mem_rd_valid;
            sram_pend       <= next_sram_pend;
            ld_reg          <= next_ld_reg;
            alu_result      <= next_alu_result;
            alu_zero        <= next_alu_zero;
            alu_carry       <= next_alu_carry;
            nvm_rd_data     <= next_nvm_rd_data;
        end
    end

    // Assertions
    a_post_inc_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ptr_upd && mem_req.mode == CRFDM_AM_POSTINC |=>
        {regs[$past(ptr_lo) + 5'h01], regs[$past(ptr_lo)]}
            == $past(ptr_val) + PTR_STEP)
        else $error("post increment step wrong");
    a_pre_dec_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        mem_req.mode == CRFDM_AM_PREDEC |-> eff_addr == ptr_val - PTR_STEP)
        else $error("pre decrement address wrong");
    a_io_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        io_rd |-> eff_addr >= IO_BASE && eff_addr < SRAM_BASE)
        else $error("io strobe outside window");
    a_upper_dst: assert property (@(posedge clk_sys) disable iff (!rst_b)
        alu_req.sel == CRFDM_SEL_IMM |-> alu_dst[REG_AW-1])
        else $error("immediate destination in lower half");
    a_alu_wb: assert property (@(posedge clk_sys) disable iff (!rst_b)
        alu_req.valid && alu_req.sel == CRFDM_SEL_ANY
        && alu_req.op == CRFDM_ALU_MOV && !mem_req.valid
        |=> regs[$past(alu_dst)] == $past(op_b))
        else $error("alu write back missing");
    a_sram_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
        mem_req.valid && !mem_req.write && rgn == CRFDM_RGN_SRAM
        |-> ##2 mem_rd_valid)
        else $error("sram load not returned in two cycles");
    a_unmapped_wr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rgn == CRFDM_RGN_NONE |-> !io_wr && !sram_wr)
        else $error("write to unmapped address");
    a_pc_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !pc_load |=> program_counter == $past(program_counter) + 10'h001)
        else $error("program counter did not step");
    c_post_inc: cover property (@(posedge clk_sys)
        mem_req.valid && mem_req.mode == CRFDM_AM_POSTINC);
    c_disp_load: cover property (@(posedge clk_sys)
        mem_req.valid && mem_req.mode == CRFDM_AM_DISP && !mem_req.write);
    c_ptr_to_reg: cover property (@(posedge clk_sys)
        mem_req.valid && mem_req.mode == CRFDM_AM_IND
        && rgn == CRFDM_RGN_REG);

endmodule : crfdm_regfile

// File: verification/crfdm_io_model.sv
// I/O peripheral stand-in for the 64-location window.
// Assumes strobes come from the block and reads answer at once.
`timescale 1ns/10ps
module crfdm_io_model
    import crfdm_pkg::*;
(
    // Clock and window
    input  wire logic              clk_sys,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    input  wire logic [IO_AW-1:0]  io_addr,
    input  wire logic [DATA_W-1:0] io_wr_data,
    output logic      [DATA_W-1:0] io_rd_data
);
    logic [DATA_W-1:0] loc [64]; // Peripheral bytes
    // Unread bus shows inverse so stale data never matches
    assign io_rd_data = io_rd ? loc[io_addr] : ~loc[io_addr];
    // Store on the strobe edge
    always @(posedge clk_sys) if (io_wr) loc[io_addr] <= io_wr_data;
endmodule : crfdm_io_model

// File: verification/crfdm_regfile_tb_top.sv
// Self-checking bench for the register file and data map.
// Assumes one 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/10ps
module crfdm_regfile_tb_top
    import crfdm_pkg::*;
;
    logic clk_sys = 0, rst_b = 0, pc_load = 0, nvm_rd = 0, nvm_wr = 0;
    logic io_wr, io_rd, mem_rd_valid, alu_zero, alu_carry;
    logic [5:0] io_addr;
    logic [6:0] nvm_addr = 0;
    logic [7:0] alu_result, mem_rd_data, io_wr_data, io_rd_data, v;
    logic [7:0] nvm_wr_data = 0, nvm_rd_data;
    logic [9:0] pc_target = 0, program_counter;
    crfdm_alu_req_s alu_req = '0;
    crfdm_mem_req_s mem_req = '0;
    int mismatches = 0, check_count = 0;
    always #5 clk_sys = ~clk_sys;
    crfdm_regfile dut (.clk_sys(clk_sys), .rst_b(rst_b), .alu_req(alu_req),
        .alu_result(alu_result), .alu_zero(alu_zero), .alu_carry(alu_carry),
        .mem_req(mem_req), .mem_rd_data(mem_rd_data),
        .mem_rd_valid(mem_rd_valid), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wr_data(io_wr_data), .io_rd_data(io_rd_data),
        .pc_load(pc_load), .pc_target(pc_target),
        .program_counter(program_counter), .nvm_rd(nvm_rd),
        .nvm_wr(nvm_wr), .nvm_addr(nvm_addr), .nvm_wr_data(nvm_wr_data),
        .nvm_rd_data(nvm_rd_data));
    crfdm_io_model io_peer (.clk_sys(clk_sys), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wr_data(io_wr_data), .io_rd_data(io_rd_data));
    task chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task alu(crfdm_alu_e o, crfdm_sel_e sl, logic [4:0] d, s, logic u,
             logic [7:0] i);
        alu_req <= '{1'b1, o, sl, d, s, u, i, 1'b0};
        @(negedge clk_sys);
    endtask : alu
    task mem(logic w, crfdm_am_e m, crfdm_ptr_e p, logic [15:0] a,
             logic [5:0] d, logic [4:0] r);
        mem_req <= '{1'b1, w, m, p, a, a[5:0], d, r};
        @(negedge clk_sys);
    endtask : mem
    // Drop both requests for one cycle
    task nop();
        alu_req.valid <= 1'b0;
        mem_req.valid <= 1'b0;
        @(negedge clk_sys);
    endtask : nop
    // Register peek through the idle ALU result path
    task pk(logic [4:0] r);
        alu_req <= '{1'b0, CRFDM_ALU_MOV, CRFDM_SEL_ANY, 5'd0, r, 1'b0,
                     8'h00, 1'b0};
        @(negedge clk_sys);
        v = alu_result;
    endtask : pk
    // Direct load, answer after n cycles
    task ld(logic [15:0] a, logic [7:0] e, int n);
        mem(1'b0, CRFDM_AM_DIRECT, CRFDM_PTR_X, a, 6'h00, 5'd0);
        mem_req.valid <= 1'b0;
        // SRAM answers one cycle later than registers and I/O
        if (n > 1) @(negedge clk_sys);
        chk(mem_rd_valid, 1'b1);
        chk(mem_rd_data, e);
        // Idle edge so the next request never rewrites valid at once
        if (n == 1) @(negedge clk_sys);
    endtask : ld
    task t_alu();
        alu(CRFDM_ALU_MOV, CRFDM_SEL_IMM, 5'd3, 5'd0, 1'b1, 8'h5a);
        alu(CRFDM_ALU_MOV, CRFDM_SEL_ANY, 5'd1, 5'd0, 1'b1, 8'h30);
        alu(CRFDM_ALU_MOV, CRFDM_SEL_ANY, 5'd2, 5'd0, 1'b1, 8'h25);
        alu(CRFDM_ALU_ADD, CRFDM_SEL_ANY, 5'd1, 5'd2, 1'b0, 8'h00);
        chk(alu_result, 8'h55);
        alu(CRFDM_ALU_ADD, CRFDM_SEL_ANY, 5'd1, 5'd2, 1'b0, 8'h00);
        chk(alu_result, 8'h7a);
        // Compare with borrow, then equal compare; neither writes back
        alu(CRFDM_ALU_CMP, CRFDM_SEL_ANY, 5'd2, 5'd1, 1'b0, 8'h00);
        chk(alu_result, 8'hab);
        chk(alu_carry, 1'b1);
        chk(alu_zero, 1'b0);
        alu(CRFDM_ALU_CMP, CRFDM_SEL_ANY, 5'd1, 5'd1, 1'b0, 8'h00);
        chk(alu_zero, 1'b1);
        chk(alu_carry, 1'b0);
        nop();
        ld(16'h0013, 8'h5a, 1);
        ld(16'h0001, 8'h7a, 1);
        $display("alu test done");
    endtask : t_alu
    task t_ptr();
        alu(CRFDM_ALU_MOV, CRFDM_SEL_ANY, 5'd26, 5'd0, 1'b1, 8'h60);
        alu(CRFDM_ALU_MOV, CRFDM_SEL_ANY, 5'd27, 5'd0, 1'b1, 8'h00);
        mem(1'b1, CRFDM_AM_POSTINC, CRFDM_PTR_X, 16'h0, 6'h0, 5'd1);
        nop();
        pk(5'd26);
        chk(v, 8'h61);
        ld(16'h0060, 8'h7a, 2);
        mem(1'b0, CRFDM_AM_PREDEC, CRFDM_PTR_X, 16'h0, 6'h0, 5'd4);
        nop();
        chk(mem_rd_data, 8'h7a);
        pk(5'd26);
        chk(v, 8'h60);
        alu(CRFDM_ALU_MOV, CRFDM_SEL_ANY, 5'd28, 5'd0, 1'b1, 8'h60);
        alu(CRFDM_ALU_MOV, CRFDM_SEL_ANY, 5'd29, 5'd0, 1'b1, 8'h00);
        mem(1'b1, CRFDM_AM_DISP, CRFDM_PTR_Y, 16'h0, 6'h3f, 5'd1);
        nop();
        ld(16'h009f, 8'h7a, 2);
        alu(CRFDM_ALU_MOV, CRFDM_SEL_ANY, 5'd26, 5'd0, 1'b1, 8'h01);
        mem(1'b0, CRFDM_AM_IND, CRFDM_PTR_X, 16'h0, 6'h0, 5'd5);
        chk(mem_rd_valid, 1'b1);
        chk(mem_rd_data, 8'h7a);
        nop();
        $display("pointer test done");
    endtask : t_ptr
    task t_io();
        mem_req <= '{1'b1, 1'b1, CRFDM_AM_IO, CRFDM_PTR_X, 16'h0, 6'h3f,
                     6'h0, 5'd1};
        #1 chk(io_wr, 1'b1);
        chk(io_addr, 6'h3f);
        chk(io_wr_data, 8'h7a);
        @(negedge clk_sys);
        nop();
        ld(16'h005f, 8'h7a, 1);
        mem(1'b1, CRFDM_AM_DIRECT, CRFDM_PTR_X, 16'h00e0, 6'h0, 5'd1);
        nop();
        ld(16'h00e0, UNDEF_RD, 1);
        $display("io test done");
    endtask : t_io
    task t_pc_nvm();
        pc_load <= 1'b1;
        pc_target <= 10'h3ff;
        nvm_wr <= 1'b1;
        nvm_addr <= 7'h7f;
        nvm_wr_data <= 8'hc3;
        @(negedge clk_sys);
        chk(program_counter, 10'h3ff);
        pc_load <= 1'b0;
        nvm_wr <= 1'b0;
        nvm_rd <= 1'b1;
        @(negedge clk_sys);
        chk(program_counter, 10'h000);
        nvm_rd <= 1'b0;
        chk(nvm_rd_data, 8'hc3);
        $display("pc and nvm test done");
    endtask : t_pc_nvm
    task finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // Hang guard, far beyond the 60 or so cycles needed
    initial begin
        #100us;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        t_alu();
        t_ptr();
        t_io();
        t_pc_nvm();
        finish_test();
    end
endmodule : crfdm_regfile_tb_top
